// File: sfd_host_model.sv
// Host controller model that streams parameter table bytes
`default_nettype none
module sfd_host_model (
  output var  logic                 ceN,
  output var  sfd_pkg::sfd_req_type hostReq,
  input  wire logic                 mclk,
  input  wire sfd_pkg::sfd_rsp_type hostRsp
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] got[$];

  // ------------------------------------------------------------
  // Idle state and byte capture
  // ------------------------------------------------------------
  initial begin
    ceN     = 1'b1;
    hostReq = '{addrValid: 1'b0, addr: 24'hFFFFFF, byteReq: 1'b0};
  end

  always @(posedge mclk) begin
    if (hostRsp.byteValid === 1'b1) begin
      got.push_back(hostRsp.byteData);
    end
  end

  // ------------------------------------------------------------
  // One access: address, n bytes with gap idle cycles, end
  // ------------------------------------------------------------
  task automatic burst(input logic [23:0] start, input int n, input int gap);
    got.delete();
    ceN               <= 1'b0;
    hostReq.addrValid <= 1'b1;
    hostReq.addr      <= start;
    @(posedge mclk);
    hostReq.addrValid <= 1'b0;
    hostReq.addr      <= ~start;
    for (int i = 0; i < n; i++) begin
      hostReq.byteReq <= 1'b1;
      @(posedge mclk);
      if (gap > 0) begin
        hostReq.byteReq <= 1'b0;
        repeat (gap) @(posedge mclk);
      end
    end
    hostReq.byteReq <= 1'b0;
    @(posedge mclk);
    ceN <= 1'b1;
    @(posedge mclk);
  endtask : burst

  // ------------------------------------------------------------
  // Open an access and leave it waiting for an address
  // ------------------------------------------------------------
  task automatic hold();
    ceN <= 1'b0;
    @(posedge mclk);
  endtask : hold

endmodule : sfd_host_model
`default_nettype wire

// File: sfd_map.svh
// Offsets, field positions, reset values and table contents
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SFD_REG_CTRL      8'h00
`define SFD_REG_STAT      8'h04
`define SFD_REG_ADDR      8'h08
`define SFD_REG_BYTES     8'h0C
`define SFD_REG_ACCESS    8'h10
`define SFD_REG_LAST      8'h14

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define SFD_CTRL_EN_BIT   0
`define SFD_CTRL_CLR_BIT  1
`define SFD_CTRL_EN_RST   1'b1
`define SFD_LAST_RST      8'hFF
`define SFD_DUMMY_LSB     0
`define SFD_MODE_LSB      5
`define SFD_ROM_AW        7

// ------------------------------------------------------------
// Table contents
// ------------------------------------------------------------
// Maker code value is arbitrary
`define SFD_MAKER_ID_DFLT 8'hA5
`define SFD_SIGNATURE     32'h50444653
`define SFD_HDR_MINOR     8'h00
`define SFD_HDR_MAJOR     8'h01
`define SFD_NPH           8'h00
`define SFD_ERASED        8'hFF
`define SFD_PH_ID         8'h00
`define SFD_PH_MINOR      8'h00
`define SFD_PH_MAJOR      8'h01
`define SFD_PH_LEN        8'h09
`define SFD_VH_MINOR      8'h00
`define SFD_VH_MAJOR      8'h01
`define SFD_VH_LEN        8'h09
`define SFD_BPT_PTR       24'h000030
`define SFD_VPT_PTR       24'h000060
`define SFD_ERASE_INFO    8'hFF
`define SFD_ERASE_4K_OP   8'h20
`define SFD_FR114_INFO    8'hB8
`define SFD_DENSITY       32'h07FFFFFF
`define SFD_FR144_DUMMY   5'h04
`define SFD_FR144_MODE    3'h2
`define SFD_FR144_OP      8'hEB
`define SFD_FR122_DUMMY   5'h04
`define SFD_FR122_MODE    3'h0
`define SFD_FR122_OP      8'hBB
`define SFD_FR_NONE       8'h00
`define SFD_FRALL_INFO    8'hEE

`endif

// File: sfd_parameter_rom.sv
// Discoverable parameter table reader with APB control and status
// Notes on behaviour
// - Bytes 00h-03h give signature LSB first; 04h reads 00h, 05h 01h.
// - Byte 06h reads 00h for one parameter header; 07h reads FFh.
// - Header: id 00h, minor 00h, major 01h, length 09h doublewords.
// - Bytes 0Ch-0Eh point to basic table at 000030h; 0Fh reads FFh.
// - Byte 10h maker code; 14h-16h point to 000060h; 17h reads FFh.
// - Byte 30h reads FFh: no 4 KB erase, coarse write granularity.
// - Byte 31h reads 20h, the 4 KB sector erase opcode.
// - Byte 32h reads B8h; byte 33h reads FFh.
// - Bytes 34h-37h give density 07FFFFFFh, low byte first.
// - Descriptor: dummy count in bits 4:0, mode bits in 7:5.
// - Byte 38h descriptor 44h, byte 39h opcode EBh.
// - Byte 3Ah descriptor 00h, byte 3Bh opcode FFh.
// - Byte 3Ch descriptor 00h, byte 3Dh opcode FFh.
// - Byte 3Eh descriptor 04h, byte 3Fh opcode BBh.
// - Byte 40h reads EEh with dual and quad support flags.
// - Bytes 41h-45h, 48h-49h read FFh; 46h 00h, 47h FFh.
//
// Register access over APB and the register offsets were chosen for this implementation.
`default_nettype none
`include "sfd_map.svh"
module sfd_parameter_rom #(
  parameter logic [7:0] MAKER_ID = `SFD_MAKER_ID_DFLT
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ceN,
  input  wire sfd_pkg::sfd_req_type hostReq,
  output sfd_pkg::sfd_rsp_type     hostRsp
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  sfd_pkg::sfd_state_type state_q;
  sfd_pkg::sfd_state_type state_d;
  logic [23:0] addr_q;
  logic [23:0] addr_d;
  logic [23:0] reqAddr_q;
  logic [23:0] reqAddr_d;
  logic        valid_q;
  logic        valid_d;
  logic        rdEn;
  logic        addrTake;
  logic [7:0]  romData;
  logic [15:0] byteCnt_q;
  logic [15:0] byteCnt_d;
  logic [15:0] accCnt_q;
  logic [15:0] accCnt_d;
  logic [7:0]  lastByte_q;
  logic [7:0]  lastByte_d;
  logic        enable_q;
  logic        enable_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        slvErr_q;
  logic        slvErr_d;
  logic        apbSetup;
  logic        apbWrite;
  logic        ctrlWrite;
  logic        clrPulse;

  // ------------------------------------------------------------
  // Table storage
  // ------------------------------------------------------------
  sfd_rom_mem #(
    .MAKER_ID (MAKER_ID)
  ) u_rom (
    .mclk   (mclk),
    .rst    (rst),
    .rdEn   (rdEn),
    .rdAddr (addr_q),
    .rdData (romData)
  );

  // ------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    addr_d    = addr_q;
    reqAddr_d = reqAddr_q;
    valid_d   = 1'b0;
    rdEn      = 1'b0;
    addrTake  = 1'b0;
    unique case (state_q)
      sfd_pkg::SFD_IDLE,
      sfd_pkg::SFD_WAIT: begin
        if (ceN) begin
          state_d = sfd_pkg::SFD_IDLE;
        end else if (enable_q || state_q == sfd_pkg::SFD_WAIT) begin
          state_d = sfd_pkg::SFD_WAIT;
          if (hostReq.addrValid) begin
            addrTake = 1'b1;
            addr_d   = hostReq.addr;
            state_d  = sfd_pkg::SFD_STREAM;
          end
        end
      end
      sfd_pkg::SFD_STREAM: begin
        if (ceN) begin
          state_d = sfd_pkg::SFD_IDLE;
        end else if (hostReq.byteReq) begin
          rdEn      = 1'b1;
          valid_d   = 1'b1;
          reqAddr_d = addr_q;
          addr_d    = addr_q + 24'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q   <= sfd_pkg::SFD_IDLE;
      addr_q    <= 24'h000000;
      reqAddr_q <= 24'h000000;
      valid_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      reqAddr_q <= reqAddr_d;
      valid_q   <= valid_d;
    end
  end

  assign hostRsp = '{byteValid: valid_q, byteData: romData};

  // ------------------------------------------------------------
  // Activity counters
  // ------------------------------------------------------------
  always_comb begin
    byteCnt_d  = clrPulse ? 16'h0000 : byteCnt_q;
    accCnt_d   = clrPulse ? 16'h0000 : accCnt_q;
    lastByte_d = lastByte_q;
    if (addrTake) begin
      byteCnt_d = 16'h0000;
      accCnt_d  = accCnt_d + 16'h0001;
    end
    if (rdEn) begin
      byteCnt_d = byteCnt_d + 16'h0001;
    end
    if (valid_q) begin
      lastByte_d = romData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      byteCnt_q  <= 16'h0000;
      accCnt_q   <= 16'h0000;
      lastByte_q <= `SFD_LAST_RST;
    end else begin
      byteCnt_q  <= byteCnt_d;
      accCnt_q   <= accCnt_d;
      lastByte_q <= lastByte_d;
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  assign apbSetup  = psel && !penable;
  assign apbWrite  = psel && penable && pwrite;
  assign ctrlWrite = apbWrite && paddr == `SFD_REG_CTRL;
  assign clrPulse  = ctrlWrite && pwdata[`SFD_CTRL_CLR_BIT];

  always_comb begin
    enable_d = enable_q;
    prdata_d = prdata_q;
    slvErr_d = slvErr_q;
    if (ctrlWrite) begin
      enable_d = pwdata[`SFD_CTRL_EN_BIT];
    end
    if (apbSetup) begin
      slvErr_d = 1'b0;
      if (!pwrite) begin
        prdata_d = 32'h00000000;
      end
      unique case (paddr)
        `SFD_REG_CTRL: begin
          if (!pwrite) begin
            prdata_d[`SFD_CTRL_EN_BIT] = enable_q;
          end
        end
        `SFD_REG_STAT: begin
          if (!pwrite) begin
            prdata_d[2:0] = {state_q, !ceN};
          end
        end
        `SFD_REG_ADDR: begin
          if (!pwrite) begin
            prdata_d[23:0] = addr_q;
          end
        end
        `SFD_REG_BYTES: begin
          if (!pwrite) begin
            prdata_d[15:0] = byteCnt_q;
          end
        end
        `SFD_REG_ACCESS: begin
          if (!pwrite) begin
            prdata_d[15:0] = accCnt_q;
          end
        end
        `SFD_REG_LAST: begin
          if (!pwrite) begin
            prdata_d[7:0] = lastByte_q;
          end
        end
        default: begin
          slvErr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_q <= `SFD_CTRL_EN_RST;
      prdata_q <= 32'h00000000;
      slvErr_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      prdata_q <= prdata_d;
      slvErr_q <= slvErr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = slvErr_q && psel && penable;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sigOrder_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q[23:2] == 22'h0 |->
      romData == 8'(`SFD_SIGNATURE >> {reqAddr_q[1:0], 3'b000}))
    else $error("signature byte wrong");

  hdrCount_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h000006 |-> romData == `SFD_NPH)
    else $error("header count byte wrong");

  hdrLength_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h00000B |-> romData == `SFD_PH_LEN)
    else $error("table length byte wrong");

  tablePtr_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h00000C |->
      romData == 8'(`SFD_BPT_PTR))
    else $error("basic table pointer wrong");

  vendorPtr_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h000014 |->
      romData == 8'(`SFD_VPT_PTR))
    else $error("vendor pointer wrong");

  eraseInfo_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h000030 |-> romData[1:0] == 2'b11)
    else $error("erase field wrong");

  eraseOp_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h000031 |->
      romData == `SFD_ERASE_4K_OP)
    else $error("erase opcode wrong");

  densityTop_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h000037 |->
      romData == `SFD_DENSITY >> 24)
    else $error("density top byte wrong");

  descFields_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h000038 |->
      romData[4:`SFD_DUMMY_LSB] == `SFD_FR144_DUMMY &&
      romData[7:`SFD_MODE_LSB] == `SFD_FR144_MODE)
    else $error("descriptor fields wrong");

  quadOp_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h000039 |-> romData == `SFD_FR144_OP)
    else $error("quad opcode wrong");

  dualOp_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h00003F |-> romData == `SFD_FR122_OP)
    else $error("dual opcode wrong");

  allFlags_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q == 24'h000040 |->
      romData == `SFD_FRALL_INFO)
    else $error("all-mode flags wrong");

  noSupport_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && reqAddr_q inside {24'h00003A, 24'h00003C, 24'h000046}
      |-> romData == `SFD_FR_NONE)
    else $error("unsupported descriptor wrong");

  erasedFill_a: assert property (
    @(posedge mclk) disable iff (rst)
    valid_q && (reqAddr_q inside {[24'h000018 : 24'h00002F]} ||
      reqAddr_q[23:7] != 17'h0) |-> romData == `SFD_ERASED)
    else $error("unlisted byte not erased");

  streamStep_a: assert property (
    @(posedge mclk) disable iff (rst)
    state_q == sfd_pkg::SFD_STREAM && !ceN && hostReq.byteReq |=>
      valid_q && reqAddr_q == $past(addr_q) &&
      addr_q == $past(addr_q) + 24'h000001)
    else $error("stream step wrong");

  ceEnd_a: assert property (
    @(posedge mclk) disable iff (rst)
    ceN |=> state_q == sfd_pkg::SFD_IDLE ##1 !valid_q)
    else $error("access did not end");

endmodule : sfd_parameter_rom
`default_nettype wire

// File: sfd_parameter_rom_test.sv
// Self-checking bench for the parameter table reader
`default_nettype none
module sfd_parameter_rom_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary maker code

  logic                 mclk;
  logic                 rst;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 ceN;
  sfd_pkg::sfd_req_type hostReq;
  sfd_pkg::sfd_rsp_type hostRsp;
  int                   errorCnt;
  int                   checkCount;
  logic [31:0]          rdWord;
  logic                 rdErr;
  logic [7:0]           head[24] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    MAKER, 8'h00, 8'h01, 8'h09, 8'h60, 8'h00, 8'h00, 8'hFF};
  logic [7:0]           body[26] = '{
    8'hFF, 8'h20, 8'hB8, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07,
    8'h44, 8'hEB, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h04, 8'hBB,
    8'hEE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF,
    8'hFF, 8'hFF};

  sfd_parameter_rom #(.MAKER_ID(MAKER)) u_dut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ceN(ceN), .hostReq(hostReq),
    .hostRsp(hostRsp)
  );

  sfd_host_model u_host (
    .ceN(ceN), .hostReq(hostReq), .mclk(mclk), .hostRsp(hostRsp)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] expByte(input int a);
    if (a < 24) return head[a];
    if (a >= 'h30 && a <= 'h49) return body[a - 'h30];
    return 8'hFF;
  endfunction : expByte

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdWord = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic err);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdWord, exp);
    chk({31'h0, rdErr}, {31'h0, err});
  endtask : rd

  task automatic seg(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      chk({24'h0, u_host.got[i]}, {24'h0, expByte(i)});
    end
  endtask : seg

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    errorCnt   = 0;
    checkCount = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'h00, 32'h1, 1'b0);
    rd(8'h04, 32'h0, 1'b0);
    rd(8'h14, 32'hFF, 1'b0);
    u_host.burst(24'h000000, 128, 0);
    chk(32'(u_host.got.size()), 32'h80);
    seg(8'h00, 8'h05);
    seg(8'h06, 8'h07);
    seg(8'h08, 8'h0B);
    seg(8'h0C, 8'h0F);
    seg(8'h10, 8'h17);
    seg(8'h18, 8'h2F);
    seg(8'h30, 8'h30);
    seg(8'h31, 8'h31);
    seg(8'h32, 8'h33);
    seg(8'h34, 8'h37);
    seg(8'h38, 8'h39);
    seg(8'h3A, 8'h3B);
    seg(8'h3C, 8'h3D);
    seg(8'h3E, 8'h3F);
    seg(8'h40, 8'h40);
    seg(8'h41, 8'h49);
    seg(8'h4A, 8'h7F);
    rd(8'h08, 32'h80, 1'b0);
    rd(8'h0C, 32'h80, 1'b0);
    rd(8'h10, 32'h1, 1'b0);
    rd(8'h14, 32'hFF, 1'b0);
    // Slow access across the address wrap
    u_host.burst(24'hFFFFFE, 4, 2);
    chk({u_host.got[0], u_host.got[1], u_host.got[2], u_host.got[3]},
        32'hFFFF_5346);
    rd(8'h08, 32'h2, 1'b0);
    rd(8'h14, 32'h46, 1'b0);
    rd(8'h10, 32'h2, 1'b0);
    // Status while streaming
    fork
      u_host.burst(24'h000037, 3, 5);
      begin
        repeat (4) @(posedge mclk);
        rd(8'h04, 32'h7, 1'b0);
      end
    join
    chk({8'h0, u_host.got[0], u_host.got[1], u_host.got[2]},
        32'h0007_44EB);
    // Counter clear, errors, read-only write
    apb(1'b1, 8'h00, 32'h3);
    rd(8'h00, 32'h1, 1'b0);
    rd(8'h0C, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    apb(1'b1, 8'h1C, 32'h1);
    chk({31'h0, rdErr}, 32'h1);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0, 1'b0);
    // Disabled block ignores a new access
    apb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 32'h0, 1'b0);
    u_host.burst(24'h000000, 2, 0);
    chk(32'(u_host.got.size()), 32'h0);
    rd(8'h10, 32'h0, 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    u_host.burst(24'h000010, 1, 0);
    chk({24'h0, u_host.got[0]}, {24'h0, MAKER});
    // Waiting access finishes after the block is disabled
    u_host.hold();
    rd(8'h04, 32'h3, 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    u_host.burst(24'h000013, 2, 0);
    chk({16'h0, u_host.got[0], u_host.got[1]}, 32'h0000_0960);
    rd(8'h10, 32'h2, 1'b0);
    // Reset in mid-run restores control and status
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'h00, 32'h1, 1'b0);
    rd(8'h10, 32'h0, 1'b0);
    rd(8'h14, 32'hFF, 1'b0);
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish();
  end

endmodule : sfd_parameter_rom_test
`default_nettype wire

// File: sfd_pkg.sv
// Types shared by the parameter table design
`default_nettype none
package sfd_pkg;

  typedef enum logic [1:0] {
    SFD_IDLE   = 2'b00,
    SFD_WAIT   = 2'b01,
    SFD_STREAM = 2'b11
  } sfd_state_type;

  typedef struct packed {
    logic        addrValid;
    logic [23:0] addr;
    logic        byteReq;
  } sfd_req_type;

  typedef struct packed {
    logic       byteValid;
    logic [7:0] byteData;
  } sfd_rsp_type;

endpackage : sfd_pkg
`default_nettype wire

// File: sfd_rom_mem.sv
// Parameter table storage with registered read data
`default_nettype none
`include "sfd_map.svh"
module sfd_rom_mem #(
  parameter logic [7:0] MAKER_ID = `SFD_MAKER_ID_DFLT
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        rdEn,
  input  wire logic [23:0] rdAddr,
  output logic      [7:0]  rdData
);

  localparam int          Depth = 1 << `SFD_ROM_AW;
  localparam logic [31:0] Sig   = `SFD_SIGNATURE;
  localparam logic [23:0] Bpt   = `SFD_BPT_PTR;
  localparam logic [23:0] Vpt   = `SFD_VPT_PTR;
  localparam logic [31:0] Dens  = `SFD_DENSITY;

  logic [7:0] romArr [Depth];
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;

  function automatic logic [7:0] fastDesc(
    input logic [2:0] modeBits,
    input logic [4:0] dummy
  );
    fastDesc = {modeBits, dummy};
  endfunction : fastDesc

  function automatic logic [7:0] romByte(input logic [6:0] a);
    unique case (a)
      7'h00: romByte = Sig[7:0];
      7'h01: romByte = Sig[15:8];
      7'h02: romByte = Sig[23:16];
      7'h03: romByte = Sig[31:24];
      7'h04: romByte = `SFD_HDR_MINOR;
      7'h05: romByte = `SFD_HDR_MAJOR;
      7'h06: romByte = `SFD_NPH;
      7'h08: romByte = `SFD_PH_ID;
      7'h09: romByte = `SFD_PH_MINOR;
      7'h0A: romByte = `SFD_PH_MAJOR;
      7'h0B: romByte = `SFD_PH_LEN;
      7'h0C: romByte = Bpt[7:0];
      7'h0D: romByte = Bpt[15:8];
      7'h0E: romByte = Bpt[23:16];
      7'h10: romByte = MAKER_ID;
      7'h11: romByte = `SFD_VH_MINOR;
      7'h12: romByte = `SFD_VH_MAJOR;
      7'h13: romByte = `SFD_VH_LEN;
      7'h14: romByte = Vpt[7:0];
      7'h15: romByte = Vpt[15:8];
      7'h16: romByte = Vpt[23:16];
      7'h30: romByte = `SFD_ERASE_INFO;
      7'h31: romByte = `SFD_ERASE_4K_OP;
      7'h32: romByte = `SFD_FR114_INFO;
      7'h34: romByte = Dens[7:0];
      7'h35: romByte = Dens[15:8];
      7'h36: romByte = Dens[23:16];
      7'h37: romByte = Dens[31:24];
      7'h38: romByte = fastDesc(`SFD_FR144_MODE, `SFD_FR144_DUMMY);
      7'h39: romByte = `SFD_FR144_OP;
      7'h3A: romByte = `SFD_FR_NONE;
      7'h3C: romByte = `SFD_FR_NONE;
      7'h3E: romByte = fastDesc(`SFD_FR122_MODE, `SFD_FR122_DUMMY);
      7'h3F: romByte = `SFD_FR122_OP;
      7'h40: romByte = `SFD_FRALL_INFO;
      7'h46: romByte = `SFD_FR_NONE;
      default: romByte = `SFD_ERASED;
    endcase
  endfunction : romByte

  for (genvar i = 0; i < Depth; i++) begin : g_rom
    assign romArr[i] = romByte(7'(i));
  end

  always_comb begin
    rdData_d = rdData_q;
    if (rdEn) begin
      if (rdAddr[23:`SFD_ROM_AW] == '0) begin
        rdData_d = romArr[rdAddr[6:0]];
      end else begin
        rdData_d = `SFD_ERASED;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData_q <= `SFD_ERASED;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign rdData = rdData_q;

endmodule : sfd_rom_mem
`default_nettype wire
